/* File: rtl/ijsr_defs.vh */
// Purpose: shared constants of the identity and scratch register bank
// Assumes: 16-bit words on the serial register port, byte-wide writes
// Notes:   offsets are byte addresses; a register spans an even/odd pair
`ifndef IJSR_DEFS_VH
`define IJSR_DEFS_VH

`define IJSR_ADDR_W         7
`define IJSR_WORD_W         16
`define IJSR_BYTE_W         8
`define IJSR_CNT_W          32
`define IJSR_TMR_W          28

`define IJSR_CMD_REG_LO     7'h68
`define IJSR_CMD_REG_HI     7'h69
`define IJSR_FACTORY_YEAR   7'h70
`define IJSR_PRODUCT_ID     7'h72
`define IJSR_LOT_SERIAL     7'h74
`define IJSR_SCRATCH_BASE   7'h76
`define IJSR_SCRATCH_TWO    7'h78
`define IJSR_SCRATCH_THREE  7'h7a
`define IJSR_FLASH_CNT_LO   7'h7c
`define IJSR_FLASH_CNT_HI   7'h7e
`define IJSR_NUM_SCRATCH    3

`define IJSR_DIN_WR_BIT     15
`define IJSR_DIN_ADDR_HI    14
`define IJSR_DIN_ADDR_LO    8
`define IJSR_DIN_DATA_HI    7

`define IJSR_CMD_FLASH_UPD  3
`define IJSR_CMD_BYTE_ZERO  8'h00
`define IJSR_WORD_ZERO      16'h0000
`define IJSR_CNT_ONE        32'h0000_0001
`define IJSR_CNT_ZERO       32'h0000_0000

// busy times chosen freely: 50 ms and 1 ms at 200 MHz, timer width
`define IJSR_FLASH_UPD_CYC  28'h098_9680
`define IJSR_OTHER_CMD_CYC  28'h003_0d40

`endif

/* File: rtl/ijsr_cmd_timer.v */
// Purpose: busy timer for one global command execution
// Assumes: start is a one-cycle pulse, ignored while busy
// Notes:   done pulses in the cycle busy falls
`timescale 1ns/10ps
`include "ijsr_defs.vh"
module ijsr_cmd_timer (
  input  wire                   clk,
  input  wire                   rst_b,
  input  wire                   start,
  input  wire [`IJSR_TMR_W-1:0] length,
  output wire                   busy,
  output reg                    done
);
  reg [`IJSR_TMR_W-1:0] cnt_q;
  reg                   busy_q;

  assign busy = busy_q;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q  <= {`IJSR_TMR_W{1'b0}};
      busy_q <= 1'b0;
      done   <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!busy_q) begin
        if (start) begin
          busy_q <= 1'b1;
          cnt_q  <= length;
        end
      end else if (cnt_q <= {{(`IJSR_TMR_W-1){1'b0}}, 1'b1}) begin
        busy_q <= 1'b0;
        done   <= 1'b1;
      end else begin
        cnt_q <= cnt_q - {{(`IJSR_TMR_W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // ijsr_cmd_timer

/* File: rtl/ijsr_regs.v */
// Purpose: identity, factory date, scratch and flash counter registers
// Assumes: serial port delivers whole 16-bit input words, one per pulse
// Notes:   flash storage lives outside; loaded by nv_load, stored by nv_store
`timescale 1ns/10ps
`include "ijsr_defs.vh"
module ijsr_regs #(
  parameter [`IJSR_WORD_W-1:0] PRODUCT_CODE  = 16'h5a5a, // arbitrary value
  parameter [`IJSR_TMR_W-1:0]  FLASH_UPD_CYC = `IJSR_FLASH_UPD_CYC,
  parameter [`IJSR_TMR_W-1:0]  OTHER_CMD_CYC = `IJSR_OTHER_CMD_CYC
) (
  input  wire                   clk,
  input  wire                   rst_b,
  input  wire                   din_valid,
  input  wire [`IJSR_WORD_W-1:0] din_word,
  output wire                   din_ready,
  output reg  [`IJSR_WORD_W-1:0] dout_word,
  input  wire                   nv_load,
  input  wire [`IJSR_WORD_W-1:0] nv_factory_year,
  input  wire [`IJSR_WORD_W-1:0] nv_serial,
  input  wire [`IJSR_WORD_W-1:0] nv_scratch_one,
  input  wire [`IJSR_WORD_W-1:0] nv_scratch_two,
  input  wire [`IJSR_WORD_W-1:0] nv_scratch_three,
  input  wire [`IJSR_CNT_W-1:0]  nv_flash_count,
  output reg                    nv_store,
  output wire [`IJSR_WORD_W-1:0] nv_store_scratch_one,
  output wire [`IJSR_WORD_W-1:0] nv_store_scratch_two,
  output wire [`IJSR_WORD_W-1:0] nv_store_scratch_three,
  output wire [`IJSR_CNT_W-1:0]  nv_store_count,
  input  wire                   sensor_ready_in,
  output wire                   data_ready_output,
  output wire                   data_hold,
  output wire                   cmd_busy
);

  // register index of a byte address, shared by read and write decode
  function [`IJSR_ADDR_W-2:0] word_index;
    input [`IJSR_ADDR_W-1:0] a;
    begin
      word_index = a[`IJSR_ADDR_W-1:1];
    end
  endfunction

  // byte address of scratch word k; an integer index avoids a sum with a
  // genvar that would come out wider than the address
  function [`IJSR_ADDR_W-1:0] scratch_addr;
    input integer k;
    begin
      scratch_addr = `IJSR_SCRATCH_BASE;
      if (k == 1) begin
        scratch_addr = `IJSR_SCRATCH_TWO;
      end else if (k == 2) begin
        scratch_addr = `IJSR_SCRATCH_THREE;
      end
    end
  endfunction

  // taken write that lands on one exact byte address
  function wr_at;
    input                    wr;
    input [`IJSR_ADDR_W-1:0] a;
    input [`IJSR_ADDR_W-1:0] target;
    begin
      wr_at = wr & (a == target);
    end
  endfunction

  reg  [`IJSR_WORD_W-1:0] factory_year_bcd_q;
  reg  [`IJSR_WORD_W-1:0] lot_serial_number_q;
  reg  [`IJSR_WORD_W-1:0] scratch_q [0:`IJSR_NUM_SCRATCH-1];
  reg  [`IJSR_CNT_W-1:0]  flash_write_count_q;
  reg  [`IJSR_BYTE_W-1:0] cmd_byte_q;
  reg  [`IJSR_TMR_W-1:0]  tmr_len;
  reg  [`IJSR_WORD_W-1:0] rd_data;
  reg                     flash_upd_q;
  wire                    tmr_busy;
  wire                    tmr_done;
  wire                    take;
  wire                    is_wr;
  wire [`IJSR_ADDR_W-1:0] addr;
  wire [`IJSR_BYTE_W-1:0] wr_byte;
  wire                    launch;
  wire                    tmr_start;
  wire                    flash_done;
  wire [`IJSR_ADDR_W-2:0] idx;

  assign take     = din_valid & ~tmr_busy;
  assign din_ready = ~tmr_busy;
  assign is_wr    = din_word[`IJSR_DIN_WR_BIT];
  assign addr     = din_word[`IJSR_DIN_ADDR_HI:`IJSR_DIN_ADDR_LO];
  assign wr_byte  = din_word[`IJSR_DIN_DATA_HI:0];
  assign idx      = word_index(addr);
  // second word of the pair starts the command held from the first
  assign launch   = wr_at(take & is_wr, addr, `IJSR_CMD_REG_HI);
  // a zero command byte launches nothing and leaves the port open
  assign tmr_start  = launch & (cmd_byte_q != `IJSR_CMD_BYTE_ZERO);
  assign flash_done = tmr_done & flash_upd_q;

  assign data_hold         = tmr_busy;
  assign data_ready_output = sensor_ready_in & ~tmr_busy;
  assign cmd_busy          = tmr_busy;

  assign nv_store_scratch_one   = scratch_q[0];
  assign nv_store_scratch_two   = scratch_q[1];
  assign nv_store_scratch_three = scratch_q[2];
  assign nv_store_count         = flash_write_count_q;

  always @* begin
    tmr_len = OTHER_CMD_CYC;
    if (cmd_byte_q[`IJSR_CMD_FLASH_UPD]) begin
      tmr_len = FLASH_UPD_CYC;
    end
  end

  ijsr_cmd_timer u_timer (
    .clk    (clk),
    .rst_b  (rst_b),
    .start  (tmr_start),
    .length (tmr_len),
    .busy   (tmr_busy),
    .done   (tmr_done)
  );

  // command byte and flash update tracking
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_byte_q  <= `IJSR_CMD_BYTE_ZERO;
      flash_upd_q <= 1'b0;
      nv_store    <= 1'b0;
    end else begin
      nv_store <= 1'b0;
      if (wr_at(take & is_wr, addr, `IJSR_CMD_REG_LO)) begin
        cmd_byte_q <= wr_byte;
      end else if (launch) begin
        flash_upd_q <= cmd_byte_q[`IJSR_CMD_FLASH_UPD];
        cmd_byte_q  <= `IJSR_CMD_BYTE_ZERO;
      end
      if (flash_done) begin
        nv_store    <= 1'b1;
        flash_upd_q <= 1'b0;
      end
    end
  end

  // identity and counter words; writes to them are dropped
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      factory_year_bcd_q  <= `IJSR_WORD_ZERO;
      lot_serial_number_q <= `IJSR_WORD_ZERO;
      flash_write_count_q <= `IJSR_CNT_ZERO;
    end else if (nv_load) begin
      factory_year_bcd_q  <= nv_factory_year;
      lot_serial_number_q <= nv_serial;
      flash_write_count_q <= nv_flash_count;
    end else if (flash_done) begin
      // count moves on the same edge that raises nv_store, so the stored copy includes this write
      flash_write_count_q <= flash_write_count_q + `IJSR_CNT_ONE;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `IJSR_NUM_SCRATCH; g = g + 1) begin : g_scr
      wire hit = take & is_wr &
                 (idx == word_index(scratch_addr(g)));
      reg [`IJSR_WORD_W-1:0] nv_val;
      always @* begin
        nv_val = nv_scratch_one;
        if (g == 1) begin
          nv_val = nv_scratch_two;
        end else if (g == 2) begin
          nv_val = nv_scratch_three;
        end
      end
      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          scratch_q[g] <= `IJSR_WORD_ZERO;
        end else if (nv_load) begin
          scratch_q[g] <= nv_val;
        end else if (hit & addr[0]) begin
          scratch_q[g][`IJSR_WORD_W-1:`IJSR_BYTE_W] <= wr_byte;
        end else if (hit) begin
          scratch_q[g][`IJSR_BYTE_W-1:0] <= wr_byte;
        end
      end
    end
  endgenerate

  // read mux; unmapped words read as zero
  always @* begin
    case (idx)
      word_index(`IJSR_FACTORY_YEAR): rd_data = factory_year_bcd_q;
      word_index(`IJSR_PRODUCT_ID):   rd_data = PRODUCT_CODE;
      word_index(`IJSR_LOT_SERIAL):   rd_data = lot_serial_number_q;
      word_index(`IJSR_SCRATCH_BASE):     rd_data = scratch_q[0];
      word_index(scratch_addr(1)):    rd_data = scratch_q[1];
      word_index(scratch_addr(2)):    rd_data = scratch_q[2];
      word_index(`IJSR_FLASH_CNT_LO):
        rd_data = flash_write_count_q[`IJSR_WORD_W-1:0];
      word_index(`IJSR_FLASH_CNT_HI):
        rd_data = flash_write_count_q[`IJSR_CNT_W-1:`IJSR_WORD_W];
      default: rd_data = `IJSR_WORD_ZERO;
    endcase
  end

  // answer goes out on the word after the request, as on the serial port
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dout_word <= `IJSR_WORD_ZERO;
    end else if (take) begin
      dout_word <= is_wr ? `IJSR_WORD_ZERO : rd_data;
    end
  end

endmodule // ijsr_regs

/* File: bench/ijsr_host_model.sv */
// Purpose: host side of the serial register port
// Assumes: called just after a rising edge
// Notes:   holds a word until the port is ready to take it
`timescale 1ns/10ps
module ijsr_host_model (
  input  wire        clk,
  input  wire        din_ready,
  output reg         din_valid,
  output reg  [15:0] din_word
);
  initial begin
    din_valid = 1'b0;
    din_word  = 16'h0000;
  end
  // last low keeps valid up for a back-to-back word
  task send(input [15:0] w, input last);
    begin
      // after a lowered valid let an edge pass, so valid never glitches
      if (!din_valid) begin
        @(posedge clk);
        #1;
      end
      din_word  = w;
      din_valid = 1'b1;
      while (!din_ready) begin
        @(posedge clk);
        #1;
      end
      @(posedge clk);
      #1;
      if (last) din_valid = 1'b0;
    end
  endtask
endmodule // ijsr_host_model

/* File: bench/ijsr_regs_properties.sv */
// Purpose: port checker for the register bank
// Assumes: single clock domain
// Notes:   flash count checked through the store port
`timescale 1ns/10ps
module ijsr_regs_chk #(
  parameter [15:0] PRODUCT_CODE = 16'h5a5a
) (
  input wire        clk,
  input wire        rst_b,
  input wire        din_valid,
  input wire [15:0] din_word,
  input wire        din_ready,
  input wire [15:0] dout_word,
  input wire        nv_load,
  input wire        nv_store,
  input wire [15:0] nv_store_scratch_one,
  input wire [31:0] nv_store_count,
  input wire        sensor_ready_in,
  input wire        data_ready_output,
  input wire        data_hold,
  input wire        cmd_busy
);
  wire tk;
  assign tk = din_valid && din_ready && !nv_load;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  busy_blocks_a: assert property (
    cmd_busy |-> !din_ready && !data_ready_output)
    else $error("port open while busy");
  ready_gate_a: assert property (
    data_hold == cmd_busy &&
    data_ready_output == (sensor_ready_in && !cmd_busy))
    else $error("data ready not gated");
  busy_dout_a: assert property (cmd_busy |=> $stable(dout_word))
    else $error("answer moved while busy");
  prod_read_a: assert property (
    tk && din_word[15:9] == 7'h39 |=> dout_word == PRODUCT_CODE)
    else $error("wrong product code");
  scratch_wr_a: assert property (
    tk && din_word[15:8] == 8'hf6 |=>
    nv_store_scratch_one[7:0] == $past(din_word[7:0]))
    else $error("scratch byte not written");
  cnt_low_a: assert property (
    tk && din_word[15:9] == 7'h3e |=>
    dout_word == $past(nv_store_count[15:0]))
    else $error("count low word wrong");
  cnt_high_a: assert property (
    tk && din_word[15:9] == 7'h3f |=>
    dout_word == $past(nv_store_count[31:16]))
    else $error("count high word wrong");
  count_step_a: assert property (
    nv_store |-> nv_store_count == $past(nv_store_count, 2) + 32'h0000_0001)
    else $error("count not stepped by one");
endmodule // ijsr_regs_chk
bind ijsr_regs ijsr_regs_chk #(.PRODUCT_CODE(PRODUCT_CODE)) u_chk (
  .clk(clk), .rst_b(rst_b), .din_valid(din_valid), .din_word(din_word),
  .din_ready(din_ready), .dout_word(dout_word), .nv_load(nv_load),
  .nv_store(nv_store), .nv_store_scratch_one(nv_store_scratch_one),
  .nv_store_count(nv_store_count), .sensor_ready_in(sensor_ready_in),
  .data_ready_output(data_ready_output), .data_hold(data_hold),
  .cmd_busy(cmd_busy));

/* File: bench/imu_identity_scratch_regs_tb_top.sv */
// Purpose: directed test of the register bank
// Assumes: short command times set by parameter
// Notes:   expected values worked out here
`timescale 1ns/10ps
module imu_identity_scratch_regs_tb_top;
  reg         clk, rst_b, nv_load, sensor_ready_in;
  reg  [15:0] nv_w [0:4];
  reg  [31:0] nv_cnt;
  reg  [7:0]  codes [0:5];
  reg  [6:0]  a;
  wire        din_valid, din_ready, nv_store, data_ready_output, cmd_busy;
  wire        dh;
  wire [15:0] din_word, dout_word, sc1, sc2, sc3;
  wire [31:0] cnt;
  integer     bad_count, total_checks, i, n;
  ijsr_host_model h (.clk(clk), .din_ready(din_ready),
    .din_valid(din_valid), .din_word(din_word));
  ijsr_regs #(.FLASH_UPD_CYC(28'h000_0014),
    .OTHER_CMD_CYC(28'h000_0005)) dut (
    .clk(clk), .rst_b(rst_b), .din_valid(din_valid), .din_word(din_word),
    .din_ready(din_ready), .dout_word(dout_word), .nv_load(nv_load),
    .nv_factory_year(nv_w[0]), .nv_serial(nv_w[1]), .nv_scratch_one(nv_w[2]),
    .nv_scratch_two(nv_w[3]), .nv_scratch_three(nv_w[4]),
    .nv_flash_count(nv_cnt), .nv_store(nv_store), .nv_store_scratch_one(sc1),
    .nv_store_scratch_two(sc2), .nv_store_scratch_three(sc3),
    .nv_store_count(cnt),
    .sensor_ready_in(sensor_ready_in), .data_ready_output(data_ready_output),
    .data_hold(dh), .cmd_busy(cmd_busy));
  task chk(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("FAIL %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task rd(input [6:0] ad, input [15:0] exp);
    begin
      h.send({1'b0, ad, 8'h00}, 1'b1);
      chk(dout_word, exp);
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // whole run needs about 130 cycles; the watchdog allows 4000
  initial begin
    #20000;
    bad_count = bad_count + 1;
    print_verdict;
  end
  initial begin
    bad_count = 0; total_checks = 0; rst_b = 1'b0; nv_load = 1'b0;
    sensor_ready_in = 1'b1; nv_cnt = 32'h0000_ffff;
    nv_w[0] = 16'h2017; nv_w[1] = 16'h1234; nv_w[2] = 16'h1111;
    nv_w[3] = 16'h2222; nv_w[4] = 16'h3333;
    codes[0] = 8'h01; codes[1] = 8'h02; codes[2] = 8'h04;
    codes[3] = 8'h10; codes[4] = 8'h80; codes[5] = 8'h08;
    repeat (20) @(posedge clk);
    #1 rst_b = 1'b1;
    @(posedge clk);
    #1 nv_load = 1'b1;
    @(posedge clk);
    #1 nv_load = 1'b0;
    rd(7'h71, 16'h2017);
    h.send(16'hf2ff, 1'b1);
    rd(7'h72, 16'h5a5a);
    h.send(16'hf400, 1'b1);
    rd(7'h75, 16'h1234);
    for (a = 7'h76; a < 7'h7c; a = a + 7'h02) begin
      rd(a, nv_w[a[3:1] - 3'd1]);
      h.send({1'b1, a, 1'b0, a}, 1'b0);
      h.send({1'b1, a + 7'h01, 8'h5a}, 1'b1);
      rd(a + 7'h01, {8'h5a, 1'b0, a});
    end
    rd(7'h7c, 16'hffff);
    rd(7'h7e, 16'h0000);
    h.send(16'he900, 1'b1);
    chk(cmd_busy, 1'b0);
    for (i = 0; i < 6; i = i + 1) begin
      h.send({8'he8, codes[i]}, 1'b0);
      h.send(16'he900, 1'b1);
      chk({cmd_busy, data_ready_output, dh}, 3'b101);
      n = 0;
      while (cmd_busy === 1'b1 && n < 100) begin
        @(posedge clk);
        #1 n = n + 1;
      end
      chk(n, (codes[i] == 8'h08) ? 20 : 5);
      chk({cmd_busy, data_ready_output, dh}, 3'b010);
    end
    @(posedge clk);
    #1 chk({nv_store, sc1}, {1'b1, 16'h5a76});
    chk({sc2, sc3}, {16'h5a78, 16'h5a7a});
    chk(cnt, 32'h0001_0000);
    rd(7'h7d, 16'h0000);
    rd(7'h7f, 16'h0001);
    sensor_ready_in = 1'b0;
    #1 chk(data_ready_output, 1'b0);
    print_verdict;
  end
endmodule // imu_identity_scratch_regs_tb_top
